// ===== inc/dma_pkg.sv
// Shared constants, state codes and carrier structs of the four-channel DMA controller.
// Assumes one byte-wide shared bus toward the core and plain configuration ports.
package dma_pkg;

  localparam int CHANNELS    = 4;
  localparam int CH_W        = 2;
  localparam int MEM_CHANNEL = 3;
  localparam int CNT_W       = 8;
  localparam int ADDR_W      = 17;
  localparam int DATA_W      = 8;
  localparam int TO_W        = 6;
  localparam int LVL_W       = 2;
  localparam int BUF_DEPTH   = 2;

  localparam logic [LVL_W-1:0]  LVL_LOW       = 2'h0;
  localparam logic [LVL_W-1:0]  LVL_MEDIUM    = 2'h1;
  localparam logic [LVL_W-1:0]  LVL_HIGH      = 2'h2;
  localparam logic [LVL_W-1:0]  LVL_VERY_HIGH = 2'h3;
  localparam logic [CNT_W-1:0]  CNT_RESET     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET    = 17'h00000;
  localparam logic [ADDR_W-1:0] STEP_BYTE     = 17'h00001;
  localparam logic [ADDR_W-1:0] STEP_WORD     = 17'h00002;
  localparam logic [TO_W-1:0]   TO_OFF        = 6'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD   = 4'h2,
    ST_WR   = 4'h4,
    ST_UPD  = 4'h8
  } dma_state_t;

  typedef struct packed {
    logic              enable;
    logic [LVL_W-1:0]  priority_level_field;
    logic              transfer_size_bit;
    logic              memory_step_direction;
    logic              auto_reload_bit;
    logic              to_periph;
    logic              mem_to_mem;
    logic              half_done_irq_enable;
    logic              all_done_irq_enable;
    logic [CNT_W-1:0]  count;
    logic [ADDR_W-1:0] periph_addr;
    logic [ADDR_W-1:0] mem0_addr;
    logic [ADDR_W-1:0] mem1_addr;
  } chan_cfg_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic              hi_prio;
    logic              lock;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_cmd_t;

endpackage : dma_pkg

// ===== rtl/byte_buffer.sv
// Small FIFO between the read and write halves of a transfer.
// Assumes the filler honours in_ready_o and the drainer honours out_valid_o.
module byte_buffer
  import dma_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      fill_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (fill_q != (PW+1)'(DEPTH));
  assign out_valid_o = (fill_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q   <= '0;
      rd_q   <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : byte_buffer

// ===== rtl/dma_controller.sv
// Four-channel DMA controller: arbiter, transfer sequencer, pointers, counts and flags.
// Assumes a byte-wide core bus granting one access per bus_gnt_i pulse, read data valid then.
// Notes on behaviour
// - Four channels; channel 3 alone may copy memory area 0 to area 1.
// - Each channel counts up to 255 items, minus one per completed transfer.
// - Two-bit level per channel picks very high, high, medium or low first.
// - Equal levels: the lower channel number wins.
// - Pending requests wait until all higher-priority ones are served.
// - A very high channel always asks the core for priority over the CPU.
// - Six-bit timeout of wait cycles after a request raises high-priority access.
// - Accessing a requesting peripheral sends it a one-cycle acknowledge.
// - Memory copy ignores requests, starts once enabled, stops at zero count.
// - 16-bit transfer: read even, read odd, write even, write odd.
// - The two reads and the two writes are never split by other accesses.
// - Memory pointer steps up or down per direction bit, copy source always up; peripheral address fixed.
// - Pointer moves one per byte, two per 16-bit transfer.
// - First transfer uses exactly the loaded peripheral and memory addresses.
// - Without auto reload, a channel at zero count serves no more requests.
// - Half the data moved sets the half flag; interrupt if enabled.
// - Count complete sets the done flag; interrupt if enabled.
// - Both flags ORed into one interrupt line per channel.
// - Channel enable plus global enable lets a channel serve its peripherals.
// - Auto reload restores the programmed count at zero and keeps serving, except in memory copy.
module dma_controller
  import dma_pkg::*;
(
  input  wire logic                                core_clk_i,
  input  wire logic                                arst_n_i,
  input  wire logic                                global_on_bit_i,
  input  wire logic [TO_W-1:0]                     bus_priority_timeout_i,
  input  wire chan_cfg_t [CHANNELS-1:0]            cfg_i,
  input  wire logic [CHANNELS-1:0]                 cfg_load_i,
  input  wire logic [CHANNELS-1:0]                 periph_req_i,
  output logic      [CHANNELS-1:0]                 periph_ack_o,
  output bus_cmd_t                                 bus_o,
  input  wire logic                                bus_gnt_i,
  input  wire logic [DATA_W-1:0]                   bus_rdata_i,
  output logic      [CHANNELS-1:0][CNT_W-1:0]      remaining_count_o,
  input  wire logic [CHANNELS-1:0]                 half_clear_i,
  input  wire logic [CHANNELS-1:0]                 done_clear_i,
  output logic      [CHANNELS-1:0]                 half_done_flag_o,
  output logic      [CHANNELS-1:0]                 all_done_flag_o,
  output logic      [CHANNELS-1:0]                 irq_o
);

  dma_state_t                     state_q;
  bus_cmd_t                       bus_q;
  logic [CHANNELS-1:0][CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0]              periph_q [CHANNELS];
  logic [ADDR_W-1:0]              mem0_q   [CHANNELS];
  logic [ADDR_W-1:0]              mem1_q;
  logic [CH_W-1:0]                chan_q;
  logic                           wide_q;
  logic                           idx_q;
  logic                           m2m_q;
  logic                           ack_on_rd_q;
  logic [ADDR_W-1:0]              src_q;
  logic [ADDR_W-1:0]              dst_q;
  logic [CHANNELS-1:0]            ack_q;
  logic [CHANNELS-1:0]            half_q;
  logic [CHANNELS-1:0]            done_q;
  logic [CHANNELS-1:0]            irq_q;
  logic [TO_W-1:0]                wait_q;

  logic [CHANNELS-1:0]            pend;
  logic                           any;
  logic [CH_W-1:0]                win;
  logic [LVL_W-1:0]               win_lvl;
  logic                           buf_in_ready;
  logic                           buf_out_valid;
  logic [DATA_W-1:0]              buf_out_data;
  logic                           rd_done;
  logic                           wr_done;
  logic [ADDR_W-1:0]              step;
  logic [CNT_W-1:0]               cnt_dec;
  logic                           upd_half;
  logic                           upd_done;
  logic                           vh_hold;
  logic                           stall_escalate;

  assign bus_o             = bus_q;
  assign periph_ack_o      = ack_q;
  assign remaining_count_o = cnt_q;
  assign half_done_flag_o  = half_q;
  assign all_done_flag_o   = done_q;
  assign irq_o             = irq_q;

  assign rd_done  = (state_q == ST_RD) & bus_q.req & bus_gnt_i;
  assign wr_done  = (state_q == ST_WR) & bus_q.req & bus_gnt_i;
  assign step     = wide_q ? STEP_WORD : STEP_BYTE;
  assign cnt_dec  = cnt_q[chan_q] - 1'b1;
  assign upd_half = (state_q == ST_UPD) & (cnt_dec == (cfg_i[chan_q].count >> 1));
  assign upd_done = (state_q == ST_UPD) & (cnt_dec == CNT_RESET);

  // Very high level is held for the whole transfer, so the first access already carries it
  assign vh_hold = (state_q == ST_IDLE)
                 ? (any & (cfg_i[win].priority_level_field == LVL_VERY_HIGH))
                 : ((state_q != ST_UPD) & (cfg_i[chan_q].priority_level_field == LVL_VERY_HIGH));
  assign stall_escalate = bus_q.req & ~bus_gnt_i & (bus_priority_timeout_i != TO_OFF)
                        & (wait_q >= bus_priority_timeout_i);

  // Two-stage arbiter: level first, then lowest channel number
  always_comb begin
    pend    = '0;
    any     = 1'b0;
    win     = '0;
    win_lvl = LVL_LOW;
    for (int c = 0; c < CHANNELS; c++) begin
      pend[c] = global_on_bit_i & cfg_i[c].enable & (cnt_q[c] != CNT_RESET)
              & (((c == MEM_CHANNEL) & cfg_i[c].mem_to_mem) | periph_req_i[c]);
      // Strict greater-than: on a tie the lower channel number, seen first, keeps the win
      if (pend[c] && (!any || cfg_i[c].priority_level_field > win_lvl)) begin
        any     = 1'b1;
        win     = CH_W'(c);
        win_lvl = cfg_i[c].priority_level_field;
      end
    end
  end

  // Read bytes wait here until the write half drains them; a wide read ends after one byte when it is full
  byte_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (rd_done),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (bus_rdata_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (wr_done),
    .out_data_o  (buf_out_data)
  );

  // Transfer sequencer and bus command
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q     <= ST_IDLE;
      bus_q       <= '0;
      chan_q      <= '0;
      wide_q      <= 1'b0;
      idx_q       <= 1'b0;
      m2m_q       <= 1'b0;
      ack_on_rd_q <= 1'b0;
      src_q       <= ADDR_RESET;
      dst_q       <= ADDR_RESET;
    end else begin
      bus_q.hi_prio <= vh_hold | stall_escalate;
      unique case (state_q)
        ST_IDLE: begin
          if (any) begin
            chan_q      <= win;
            wide_q      <= cfg_i[win].transfer_size_bit;
            idx_q       <= 1'b0;
            m2m_q       <= (win == CH_W'(MEM_CHANNEL)) & cfg_i[win].mem_to_mem;
            ack_on_rd_q <= ~cfg_i[win].to_periph;
            if ((win == CH_W'(MEM_CHANNEL)) & cfg_i[win].mem_to_mem) begin
              src_q <= mem0_q[win];
              dst_q <= mem1_q;
            end else if (cfg_i[win].to_periph) begin
              src_q <= mem0_q[win];
              dst_q <= periph_q[win];
            end else begin
              src_q <= periph_q[win];
              dst_q <= mem0_q[win];
            end
            bus_q.addr <= cfg_i[win].to_periph | ((win == CH_W'(MEM_CHANNEL))
                          & cfg_i[win].mem_to_mem) ? mem0_q[win] : periph_q[win];
            bus_q.we   <= 1'b0;
            bus_q.req  <= 1'b1;
            bus_q.lock <= 1'b1;
            state_q    <= ST_RD;
          end
        end
        ST_RD: begin
          // A wide read keeps the request up and only moves the address to the odd byte
          if (rd_done) begin
            if (wide_q && !idx_q && buf_in_ready) begin
              idx_q      <= 1'b1;
              bus_q.addr <= src_q + STEP_BYTE;
            end else begin
              idx_q     <= 1'b0;
              bus_q.req <= 1'b0;
              state_q   <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (wr_done) begin
            bus_q.req <= 1'b0;
            if (wide_q && !idx_q) begin
              idx_q <= 1'b1;
            end else begin
              state_q <= ST_UPD;
            end
          end else if (!bus_q.req && buf_out_valid) begin
            // Write half always drains even byte first, then odd
            bus_q.req   <= 1'b1;
            bus_q.we    <= 1'b1;
            bus_q.addr  <= idx_q ? dst_q + STEP_BYTE : dst_q;
            bus_q.wdata <= buf_out_data;
          end
        end
        ST_UPD: begin
          bus_q.lock <= 1'b0;
          bus_q.we   <= 1'b0;
          state_q    <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          bus_q   <= '0;
        end
      endcase
    end
  end

  // Cycles spent waiting for a grant since the last request
  // Saturates, so a very long stall keeps the escalation asserted
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= TO_OFF;
    end else if (!bus_q.req || bus_gnt_i) begin
      wait_q <= TO_OFF;
    end else if (wait_q != {TO_W{1'b1}}) begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // One-cycle acknowledge on the first peripheral-side access of a transfer
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= '0;
    end else begin
      ack_q <= '0;
      if (!m2m_q && !idx_q && ((rd_done && ack_on_rd_q) || (wr_done && !ack_on_rd_q))) begin
        ack_q[chan_q] <= 1'b1;
      end
    end
  end

  // Counts and pointers; a load copies the programmed values in
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= '0;
      mem1_q <= ADDR_RESET;
      for (int c = 0; c < CHANNELS; c++) begin
        periph_q[c] <= ADDR_RESET;
        mem0_q[c]   <= ADDR_RESET;
      end
    end else begin
      // Reload restores the count only; the pointers carry on from where they stopped
      if (state_q == ST_UPD) begin
        if (cnt_dec != CNT_RESET) begin
          cnt_q[chan_q] <= cnt_dec;
        end else if (cfg_i[chan_q].auto_reload_bit && !m2m_q) begin
          cnt_q[chan_q] <= cfg_i[chan_q].count;
        end else begin
          cnt_q[chan_q] <= CNT_RESET;
        end
        if (m2m_q) begin
          mem0_q[chan_q] <= mem0_q[chan_q] + step;  // Copy source always counts up
          mem1_q <= cfg_i[chan_q].memory_step_direction ? mem1_q - step : mem1_q + step;
        end else begin
          mem0_q[chan_q] <= cfg_i[chan_q].memory_step_direction ?
                            mem0_q[chan_q] - step : mem0_q[chan_q] + step;
        end
      end
      // A load during this channel's own update overrides that update; software loads while disabled
      for (int c = 0; c < CHANNELS; c++) begin
        if (cfg_load_i[c]) begin
          cnt_q[c]    <= cfg_i[c].count;
          periph_q[c] <= cfg_i[c].periph_addr;
          mem0_q[c]   <= cfg_i[c].mem0_addr;
          if (c == MEM_CHANNEL) begin
            mem1_q <= cfg_i[c].mem1_addr;
          end
        end
      end
    end
  end

  // Event flags: a set in the same cycle as a clear wins
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_q <= '0;
      done_q <= '0;
      irq_q  <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        half_q[c] <= (upd_half & (chan_q == CH_W'(c))) | (half_q[c] & ~half_clear_i[c]);
        done_q[c] <= (upd_done & (chan_q == CH_W'(c))) | (done_q[c] & ~done_clear_i[c]);
        irq_q[c]  <= (half_q[c] & cfg_i[c].half_done_irq_enable)
                   | (done_q[c] & cfg_i[c].all_done_irq_enable);
      end
    end
  end

endmodule : dma_controller

// ===== testbench/dma_controller_properties.sv
// Concurrent checks on the DMA controller's bus, acknowledge, flag and interrupt ports.
// Assumes one clock domain; bound to the controller from the testbench top file.
module dma_controller_properties
  import dma_pkg::*;
(
  input wire logic                           core_clk_i,
  input wire logic                           arst_n_i,
  input wire logic [TO_W-1:0]                bus_priority_timeout_i,
  input wire chan_cfg_t [CHANNELS-1:0]       cfg_i,
  input wire logic [CHANNELS-1:0]            periph_ack_o,
  input wire bus_cmd_t                       bus_o,
  input wire logic                           bus_gnt_i,
  input wire logic [CHANNELS-1:0][CNT_W-1:0] remaining_count_o,
  input wire logic [CHANNELS-1:0]            half_done_flag_o,
  input wire logic [CHANNELS-1:0]            all_done_flag_o,
  input wire logic [CHANNELS-1:0]            irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [CHANNELS-1:0] irq_src;
  logic [CHANNELS-1:0] done_ok;
  logic                any_vh;
  always_comb begin
    any_vh = 1'b0;
    for (int c = 0; c < CHANNELS; c++) begin
      irq_src[c] = (half_done_flag_o[c] & cfg_i[c].half_done_irq_enable)
                 | (all_done_flag_o[c] & cfg_i[c].all_done_irq_enable);
      // Auto reload refills the count on the edge the done flag rises
      done_ok[c] = (remaining_count_o[c] == CNT_RESET) | cfg_i[c].auto_reload_bit;
      any_vh = any_vh | (cfg_i[c].enable & (cfg_i[c].priority_level_field == LVL_VERY_HIGH));
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_rd_gnt;
    bus_o.req && !bus_o.we && bus_gnt_i;
  endsequence
  sequence s_wr_gnt;
    bus_o.req && bus_o.we && bus_gnt_i;
  endsequence
  chk_ack_pulse_width: assert property (
    (periph_ack_o != '0) |=> ((periph_ack_o & $past(periph_ack_o)) == '0))
    else $error("acknowledge longer than one cycle");
  chk_ack_after_grant: assert property (
    (periph_ack_o != '0) |-> $past(bus_gnt_i && bus_o.req))
    else $error("acknowledge without a granted access");
  chk_req_holds_steady: assert property (
    (bus_o.req && !bus_gnt_i) |=> bus_o.req && $stable(bus_o.addr) && $stable(bus_o.we))
    else $error("bus request changed before grant");
  chk_lock_covers_req: assert property (bus_o.req |-> bus_o.lock)
    else $error("bus access without lock");
  chk_word_read_pair: assert property (
    s_rd_gnt ##1 (bus_o.req && !bus_o.we) |-> bus_o.addr == $past(bus_o.addr) + STEP_BYTE)
    else $error("second read not at the odd address");
  chk_word_write_pair: assert property (
    s_wr_gnt ##1 (!bus_o.req && bus_o.lock) ##1 bus_o.req
      |-> bus_o.we && bus_o.addr == $past(bus_o.addr, 2) + STEP_BYTE)
    else $error("second write not at the odd address");
  chk_irq_from_flags: assert property (irq_o == $past(irq_src))
    else $error("interrupt line does not follow the flags");
  chk_no_hi_prio: assert property (
    (!any_vh && bus_priority_timeout_i == TO_OFF) [*2] |-> !bus_o.hi_prio)
    else $error("high priority without cause");
  chk_done_at_zero: assert property (
    (all_done_flag_o & ~$past(all_done_flag_o) & ~done_ok) == '0)
    else $error("done flag set with count left");
endmodule : dma_controller_properties

// ===== testbench/core_bus_model.sv
// Far side: the shared core bus granting accesses, and peripherals raising requests.
// Assumes registered bus commands; a grant follows bus_wait_i waiting cycles.
module core_bus_model
  import dma_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire bus_cmd_t            bus_i,
  input  wire logic [3:0]          bus_wait_i,
  input  wire logic [CHANNELS-1:0] ack_i,
  output logic                     gnt_o,
  output logic      [DATA_W-1:0]   rdata_o,
  output logic      [CHANNELS-1:0] req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int                cnt_q = 0;
  int                pend[CHANNELS] = '{default: 0};
  int                acks[CHANNELS] = '{default: 0};
  logic [ADDR_W-1:0] wa_q[$];
  logic [DATA_W-1:0] wd_q[$];
  initial begin
    gnt_o = 1'b0;
    rdata_o = 8'h00;
    req_o = '0;
  end
  always @(posedge core_clk_i) begin
    if (gnt_o && bus_i.req && bus_i.we) begin
      wa_q.push_back(bus_i.addr);
      wd_q.push_back(bus_i.wdata);
    end
    for (int c = 0; c < CHANNELS; c++) begin
      if (ack_i[c]) begin
        acks[c]++;
        pend[c] = (pend[c] > 0) ? pend[c] - 1 : 0;
      end
    end
    #1;
    for (int c = 0; c < CHANNELS; c++) req_o[c] = (pend[c] != 0);
    if (!gnt_o && bus_i.req && cnt_q >= bus_wait_i) begin
      gnt_o = 1'b1;
      rdata_o = bus_i.addr[7:0] ^ 8'h5A;
      cnt_q = 0;
    end else begin
      gnt_o = 1'b0;
      // A released data bus must not keep showing the last byte
      rdata_o = ~rdata_o;
      cnt_q = bus_i.req ? cnt_q + 1 : 0;
    end
  end
endmodule : core_bus_model

// ===== testbench/dma_controller_tb_top.sv
// Top testbench: directed transfers checked against the bus model's write log.
// Assumes the bus model answers a read with the low address byte XOR 5A.
module dma_controller_tb_top
  import dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                           core_clk_i = 1'b0;
  logic                           arst_n_i = 1'b0;
  logic                           global_on_bit_i = 1'b0;
  logic [TO_W-1:0]                timeout = TO_OFF;
  chan_cfg_t [CHANNELS-1:0]       cfg = '0;
  logic [CHANNELS-1:0]            load = '0;
  logic [CHANNELS-1:0]            hclr = '0;
  logic [CHANNELS-1:0]            dclr = '0;
  logic [CHANNELS-1:0]            preq, ack, hflag, dflag, irq;
  logic [CHANNELS-1:0][CNT_W-1:0] cnt;
  bus_cmd_t                       bus;
  logic                           gnt;
  logic [DATA_W-1:0]              rdata;
  logic [3:0]                     bus_wait = 4'h0;
  logic                           saw_hi = 1'b0;
  int                             num_errors = 0;
  int                             n_compared = 0;

  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (bus.req && bus.hi_prio) saw_hi <= 1'b1;

  dma_controller dma_controller_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .global_on_bit_i(global_on_bit_i), .bus_priority_timeout_i(timeout), .cfg_i(cfg),
    .cfg_load_i(load), .periph_req_i(preq), .periph_ack_o(ack), .bus_o(bus), .bus_gnt_i(gnt),
    .bus_rdata_i(rdata), .remaining_count_o(cnt), .half_clear_i(hclr), .done_clear_i(dclr),
    .half_done_flag_o(hflag), .all_done_flag_o(dflag), .irq_o(irq));
  core_bus_model core_bus_model_inst (.core_clk_i(core_clk_i), .bus_i(bus),
    .bus_wait_i(bus_wait), .ack_i(ack), .gnt_o(gnt), .rdata_o(rdata), .req_o(preq));

  function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : pat
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  // Mode bits md: size, step down, auto reload, toward peripheral, memory copy
  task automatic load_ch(input int ch, input logic [1:0] lvl, input logic [4:0] md,
      input logic [7:0] n, input logic [ADDR_W-1:0] pa, ma, m1);
    cfg[ch] = '{1'b1, lvl, md[4], md[3], md[2], md[1], md[0], 1'b1, 1'b1, n, pa, ma, m1};
    load[ch] = 1'b1;
    tick(1);
    load[ch] = 1'b0;
  endtask : load_ch
  task automatic wait_writes(input int n);
    int k;
    k = 0;
    while (core_bus_model_inst.wa_q.size() < n && k < 400) begin
      tick(1);
      k++;
    end
    check(k < 400, 1);
    tick(4);
  endtask : wait_writes
  task automatic clear_all();
    hclr = '1;
    dclr = '1;
    tick(1);
    hclr = '0;
    dclr = '0;
    tick(2);
    core_bus_model_inst.wa_q.delete();
    core_bus_model_inst.wd_q.delete();
  endtask : clear_all
  task automatic end_of_test();
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  initial begin
    tick(8);
    arst_n_i = 1'b1;
    tick(1);
    check(cnt, '0);
    load_ch(0, LVL_LOW, 5'b00000, 8'h04, 17'h05210, 17'h00100, ADDR_RESET);
    core_bus_model_inst.pend[0] = 2;
    tick(20);
    check(core_bus_model_inst.acks[0], 0);
    global_on_bit_i = 1'b1;
    wait_writes(2);
    check({hflag[0], dflag[0], irq[0]}, 3'b101);
    core_bus_model_inst.pend[0] = 2;
    wait_writes(4);
    for (int i = 0; i < 4; i++) begin
      check(core_bus_model_inst.wa_q[i], 17'h00100 + i);
      check(core_bus_model_inst.wd_q[i], pat(17'h05210));
    end
    check({dflag[0], irq[0], cnt[0]}, {2'b11, CNT_RESET});
    check(core_bus_model_inst.acks[0], 4);
    core_bus_model_inst.pend[0] = 1;
    tick(30);
    check(core_bus_model_inst.wa_q.size(), 4);
    core_bus_model_inst.pend[0] = 0;
    clear_all();
    check({hflag, dflag, irq}, '0);
    bus_wait = 4'h2;
    load_ch(1, LVL_HIGH, 5'b11010, 8'h02, 17'h05300, 17'h00208, ADDR_RESET);
    core_bus_model_inst.pend[1] = 2;
    wait_writes(4);
    for (int i = 0; i < 4; i++) begin
      check(core_bus_model_inst.wa_q[i], 17'h05300 + i % 2);
      check(core_bus_model_inst.wd_q[i], pat(ADDR_W'(17'h00208 - 2 * (i / 2) + i % 2)));
    end
    check(core_bus_model_inst.acks[1], 2);
    clear_all();
    bus_wait = 4'h0;
    global_on_bit_i = 1'b0;
    load_ch(0, LVL_LOW, 5'b00000, 8'h01, 17'h05210, 17'h00300, ADDR_RESET);
    load_ch(1, LVL_HIGH, 5'b00000, 8'h01, 17'h05211, 17'h00310, ADDR_RESET);
    load_ch(2, LVL_HIGH, 5'b00000, 8'h01, 17'h05212, 17'h00320, ADDR_RESET);
    for (int c = 0; c < 3; c++) core_bus_model_inst.pend[c] = 1;
    tick(2);
    global_on_bit_i = 1'b1;
    wait_writes(3);
    check(core_bus_model_inst.wa_q[0], 17'h00310);
    check(core_bus_model_inst.wa_q[1], 17'h00320);
    check(core_bus_model_inst.wa_q[2], 17'h00300);
    clear_all();
    saw_hi = 1'b0;
    core_bus_model_inst.pend[3] = 1;
    load_ch(3, LVL_VERY_HIGH, 5'b00001, 8'h03, 17'h05000, 17'h10000, 17'h00100);
    wait_writes(3);
    tick(20);
    check(core_bus_model_inst.wa_q.size(), 3);
    for (int i = 0; i < 3; i++) begin
      check(core_bus_model_inst.wa_q[i], 17'h00100 + i);
      check(core_bus_model_inst.wd_q[i], pat(ADDR_W'(17'h10000 + i)));
    end
    check(saw_hi, 1'b1);
    check(core_bus_model_inst.acks[3], 0);
    core_bus_model_inst.pend[3] = 0;
    cfg[3].enable = 1'b0;
    clear_all();
    saw_hi = 1'b0;
    bus_wait = 4'hC;
    timeout = 6'h03;
    load_ch(2, LVL_LOW, 5'b00000, 8'h01, 17'h05212, 17'h00330, ADDR_RESET);
    core_bus_model_inst.pend[2] = 1;
    wait_writes(1);
    check(saw_hi, 1'b1);
    clear_all();
    timeout = TO_OFF;
    bus_wait = 4'h0;
    load_ch(0, LVL_LOW, 5'b00100, 8'h02, 17'h05210, 17'h00400, ADDR_RESET);
    core_bus_model_inst.pend[0] = 3;
    wait_writes(3);
    check(cnt[0], 8'h01);
    check(core_bus_model_inst.wa_q[2], 17'h00402);
    end_of_test();
  end

  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end
endmodule : dma_controller_tb_top

bind dma_controller dma_controller_properties dma_controller_properties_inst (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .bus_priority_timeout_i(bus_priority_timeout_i),
  .cfg_i(cfg_i), .periph_ack_o(periph_ack_o), .bus_o(bus_o), .bus_gnt_i(bus_gnt_i),
  .remaining_count_o(remaining_count_o), .half_done_flag_o(half_done_flag_o),
  .all_done_flag_o(all_done_flag_o), .irq_o(irq_o));
